// ==== ext_bus_cfg.svh ====
`ifndef EXT_BUS_CFG_SVH
`define EXT_BUS_CFG_SVH

// Clock rate in kHz
`define CLK_KHZ 20000
// Least reset low time in system clock cycles
`define RESET_MIN_CYCLES 3
// Address and data widths
`define ADDR_W 24
`define DATA_W 8
// Interrupt source count and vector width
`define IRQ_W 8
`define VEC_W 3

`endif

// ==== ext_bus_pkg.sv ====
`include "ext_bus_cfg.svh"

package ext_bus_pkg;

    // Kind of access the core asks for
    typedef enum logic [3:0] {
        ACC_MEM_RD   = 4'h1,
        ACC_MEM_WR   = 4'h2,
        ACC_IO_RD    = 4'h4,
        ACC_IO_WR    = 4'h8
    } access_e;

    // Bus cycle sequencer states
    typedef enum logic [4:0] {
        ST_IDLE    = 5'h01,
        ST_ADDR    = 5'h02,
        ST_STROBE  = 5'h04,
        ST_FLOAT   = 5'h08,
        ST_GRANTED = 5'h10
    } bus_state_e;

    // Request from the core
    typedef struct packed {
        logic                  valid;
        access_e               kind;
        logic                  fetch;
        logic [`ADDR_W-1:0]    addr;
        logic [`DATA_W-1:0]    wdata;
    } core_req_s;

    // Drive set of the pins
    typedef struct packed {
        logic [`ADDR_W-1:0]    addr;
        logic                  addr_oe;
        logic [`DATA_W-1:0]    data;
        logic                  data_oe;
        logic                  ioreq_n;
        logic                  memreq_n;
        logic                  req_oe;
        logic                  rd_n;
        logic                  wr_n;
        logic                  strobe_oe;
        logic                  fetch_n;
        logic                  grant_n;
    } pin_drive_s;

    // Whole state of the block
    typedef struct packed {
        bus_state_e            state;
        pin_drive_s            pins;
        logic [`DATA_W-1:0]    rdata;
        logic                  done;
        logic                  busy;
        logic [1:0]            wait_sync;
        logic [1:0]            bus_release_request_n_sync;
        logic [1:0]            nmi_sync;
        logic                  nmi_prev;
        logic                  nmi_pend;
        logic                  take;
        logic                  take_nmi;
        logic [`VEC_W-1:0]     vector;
    } bus_regs_s;

endpackage

// ==== cpu_external_bus_interface.sv ====
`include "ext_bus_cfg.svh"

module cpu_external_bus_interface
    import ext_bus_pkg::*;
(
    input  wire logic                 clk_in,
    input  wire logic                 reset_n_in,
    // Core side
    input  wire core_req_s            core_req_in,
    // Interrupt service, decided on the instruction end strobe
    input  wire logic                 instr_end_in,
    input  wire logic                 irq_enable_in,
    input  wire logic [`IRQ_W-1:0]    irq_lines_in,
    output logic                      core_busy_out,
    output logic                      core_done_out,
    output logic [`DATA_W-1:0]        core_rdata_out,
    output logic                      int_take_out,
    output logic                      int_nmi_out,
    output logic [`VEC_W-1:0]         int_vector_out,
    // Pin side
    input  wire logic [`DATA_W-1:0]   data_pin_in,
    input  wire logic                 wait_n_in,
    input  wire logic                 bus_release_request_n_in,
    input  wire logic                 nmi_n_in,
    // Pin drives, each group but fetch flag and grant with its output enable
    output logic [`ADDR_W-1:0]        addr_out,
    output logic                      addr_oe_out,
    output logic [`DATA_W-1:0]        data_out,
    output logic                      data_oe_out,
    output logic                      io_space_request_n_out,
    output logic                      memory_space_request_n_out,
    output logic                      space_request_oe_out,
    output logic                      read_n_out,
    output logic                      write_n_out,
    output logic                      strobe_oe_out,
    output logic                      instruction_fetch_flag_n_out,
    output logic                      bus_release_grant_n_out
);

    // Reset is sampled asynchronously; its minimum width and the
    // stable clock are the reset source's job

    // Access timing, counted from the edge that takes the request:
    //   edge 1  address, space request and any write data go out
    //   edge 2  read or write strobe falls, fetch flag with a fetch
    //   edge 3  strobe, request and write data end, done pulses
    // A slow part holds the access in edge 3 for as long as its wait
    // line is seen low. Wait passes two flip-flops, so the level seen
    // at edge 3 is the one the pin had at edge 1: a part that cannot
    // pull wait low that early cannot stretch the access at all. This
    // costs latency but keeps a pin edge off the sequencer's inputs.
    // Write data is driven only while an own write is in flight; at
    // all other times the data enable stays low so parts can answer.
    // Release timing, counted from the edge that sees the request:
    //   edge 1  float state entered, busy rises
    //   edge 2  address, request and strobe enables drop
    //   edge 3  grant falls
    // A release never cuts an access; it waits for the idle state,
    // and it wins over a core request arriving in the same cycle.
    // Interrupts are only decided on the instruction end strobe; the
    // nonmaskable line is latched on its falling edge so a short low
    // pulse is not lost while an instruction runs.

    // One packed struct holds every flip-flop of the block
    bus_regs_s q;                       // Registered state
    bus_regs_s d;                       // Next state

    // Pins in their idle, bus-owning shape
    // The address is kept, so the lines do not toggle between
    // accesses and draw no needless switching current
    function automatic pin_drive_s idle_pins(input logic [`ADDR_W-1:0] a);
        pin_drive_s p;
        p           = '0;
        // Strobes and requests high, enables but data on, no grant
        p.addr      = a;
        p.addr_oe   = 1'b1;
        p.ioreq_n   = 1'b1;
        p.memreq_n  = 1'b1;
        p.req_oe    = 1'b1;
        p.rd_n      = 1'b1;
        p.wr_n      = 1'b1;
        p.strobe_oe = 1'b1;
        p.fetch_n   = 1'b1;
        p.grant_n   = 1'b1;
        return p;
    endfunction

    // Lowest numbered pending maskable source
    // Fixed priority keeps the decode small; a line that stays high
    // starves every higher numbered one until it is served
    function automatic logic [`VEC_W-1:0] pick(input logic [`IRQ_W-1:0] r);
        logic [`VEC_W-1:0] v;
        v = '0;
        for (int i = `IRQ_W - 1; i >= 0; i--) begin
            // Scan down so the lowest index is written last
            if (r[i]) begin
                v = i[`VEC_W-1:0];
            end
        end
        return v;
    endfunction

    // Synchronised pin levels, read only from the second stage
    // Stages start high, the idle level of these lines, so reset
    // leaves no false wait, request or falling edge behind
    logic wait_low;                     // Wait held by a slow part
    logic bus_release_request_n_low;                   // External master asks for bus
    logic nmi_low;                      // Nonmaskable line active
    assign wait_low   = ~q.wait_sync[1];
    assign bus_release_request_n_low = ~q.bus_release_request_n_sync[1];
    assign nmi_low    = ~q.nmi_sync[1];

    // Next-state logic
    // Every field starts from its held value; only the one-cycle
    // pulses fall back to zero on their own
    always_comb begin
        d = q;
        d.done     = 1'b0;
        d.take     = 1'b0;
        d.take_nmi = 1'b0;

        // Two flip-flops ahead of any use of the wait, release request and nonmaskable pins
        d.wait_sync   = {q.wait_sync[0], wait_n_in};
        d.bus_release_request_n_sync = {q.bus_release_request_n_sync[0], bus_release_request_n_in};
        d.nmi_sync    = {q.nmi_sync[0], nmi_n_in};
        d.nmi_prev    = nmi_low;

        // Falling edge latches the nonmaskable request
        // A line held low counts once; it must rise before it counts again
        if (nmi_low && !q.nmi_prev) begin
            d.nmi_pend = 1'b1;
        end

        // Service decision at the end of an instruction
        // The nonmaskable request is checked first, so it outranks any
        // enabled maskable line pending at the same instruction end
        if (instr_end_in) begin
            if (q.nmi_pend) begin
                // Ignores the enable and outranks the rest
                d.take     = 1'b1;
                d.take_nmi = 1'b1;
                d.nmi_pend = nmi_low && !q.nmi_prev;
            end else if (irq_enable_in && |irq_lines_in) begin
                d.take   = 1'b1;
                d.vector = pick(irq_lines_in);
            end
        end

        // Bus cycle sequencer; a stray one-hot code falls to the
        // default arm and parks the bus idle
        unique case (q.state)
            // Bus owned, no access in flight
            ST_IDLE: begin
                d.pins = idle_pins(q.pins.addr);
                if (bus_release_request_n_low) begin
                    // Release only between accesses
                    // A core request in this cycle is dropped; the
                    // core must keep valid high until busy rises
                    d.state = ST_FLOAT;
                    d.busy  = 1'b1;
                end else if (core_req_in.valid) begin
                    // Address, qualifiers and write data leave together
                    d.busy       = 1'b1;
                    d.state      = ST_ADDR;
                    d.pins.addr  = core_req_in.addr;
                    d.pins.data  = core_req_in.wdata;
                    // Space qualifiers
                    d.pins.ioreq_n = !(core_req_in.kind inside
                                       {ACC_IO_RD, ACC_IO_WR});
                    d.pins.memreq_n = !(core_req_in.kind inside
                                        {ACC_MEM_RD, ACC_MEM_WR});
                    // Write data goes out only on own writes
                    d.pins.data_oe = core_req_in.kind inside
                                     {ACC_MEM_WR, ACC_IO_WR};
                end
            end

            // Address settled, strobe about to fall
            ST_ADDR: begin
                // Strobe after address has settled a cycle
                d.state = ST_STROBE;
                d.pins.rd_n = !(q.pins.data_oe == 1'b0);
                d.pins.wr_n = !q.pins.data_oe;
                // Fetch flag only on memory reads marked as fetches
                d.pins.fetch_n = !(core_req_in.fetch
                                   && !q.pins.memreq_n
                                   && !q.pins.data_oe);
            end

            // Strobe low, waiting out the slow part
            ST_STROBE: begin
                // Stretch while the slow part holds wait
                if (!wait_low) begin
                    // Read data comes straight off the pins: the bus
                    // runs on this clock, so the part holds it stable here
                    d.rdata = data_pin_in;
                    d.done  = 1'b1;
                    d.busy  = 1'b0;
                    d.state = ST_IDLE;
                    d.pins  = idle_pins(q.pins.addr);
                end
            end

            // Own drives let go, grant still high
            ST_FLOAT: begin
                // Tri-state address, requests, strobes and data before the grant
                d.pins         = idle_pins(q.pins.addr);
                d.pins.addr_oe   = 1'b0;
                d.pins.req_oe    = 1'b0;
                d.pins.strobe_oe = 1'b0;
                d.state        = ST_GRANTED;
            end

            // Outside master owns the bus
            ST_GRANTED: begin
                // Grant follows the float by one cycle
                d.pins.grant_n = !bus_release_request_n_low;
                if (!bus_release_request_n_low) begin
                    // Take the bus back
                    // Drive and grant return on one edge; the master
                    // must let go of the lines before it drops its request
                    d.pins  = idle_pins(q.pins.addr);
                    d.state = ST_IDLE;
                    d.busy  = 1'b0;
                end else begin
                    // Hold the grant while the request stays low
                    d.pins.grant_n = 1'b0;
                end
            end

            // Illegal code: back to idle with the pins at rest
            default: begin
                d.state = ST_IDLE;
                d.pins  = idle_pins(q.pins.addr);
            end
        endcase
    end

    // State register. Reset puts the pins in their idle, bus-owning
    // shape: strobes and requests high, all enables but data on, no grant and
    // no write data; the synchronisers start at the idle high level
    // of their pins so no false edge or wait follows reset
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            q             <= '0;
            q.state       <= ST_IDLE;
            // Pins at rest: strobes and requests high, enables but data on
            q.pins.addr_oe   <= 1'b1;
            q.pins.ioreq_n   <= 1'b1;
            q.pins.memreq_n  <= 1'b1;
            q.pins.req_oe    <= 1'b1;
            q.pins.rd_n      <= 1'b1;
            q.pins.wr_n      <= 1'b1;
            q.pins.strobe_oe <= 1'b1;
            q.pins.fetch_n   <= 1'b1;
            q.pins.grant_n   <= 1'b1;
            q.wait_sync   <= 2'h3;
            q.bus_release_request_n_sync <= 2'h3;
            q.nmi_sync    <= 2'h3;
            q.nmi_prev    <= 1'b0;
        end else begin
            // Whole state advances together on the clock
            q <= d;
        end
    end

    // Outputs straight from the state register
    // No logic sits between a flip-flop and a pin, so every output
    // settles right after the clock edge
    // Core side results
    assign core_busy_out                = q.busy;
    assign core_done_out                = q.done;
    assign core_rdata_out               = q.rdata;
    assign int_take_out                 = q.take;
    assign int_nmi_out                  = q.take_nmi;
    assign int_vector_out               = q.vector;
    // Pin drives; an enable is high while this block drives the pin
    assign addr_out                     = q.pins.addr;
    assign addr_oe_out                  = q.pins.addr_oe;
    assign data_out                     = q.pins.data;
    assign data_oe_out                  = q.pins.data_oe;
    assign io_space_request_n_out       = q.pins.ioreq_n;
    assign memory_space_request_n_out   = q.pins.memreq_n;
    assign space_request_oe_out         = q.pins.req_oe;
    assign read_n_out                   = q.pins.rd_n;
    assign write_n_out                  = q.pins.wr_n;
    assign strobe_oe_out                = q.pins.strobe_oe;
    assign instruction_fetch_flag_n_out = q.pins.fetch_n;
    assign bus_release_grant_n_out      = q.pins.grant_n;

endmodule

// ==== cpu_external_bus_interface_properties.sv ====
// Watches the pin side of the bus block
module cpu_external_bus_interface_checker (
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic wait_n_in,
    input wire logic core_done_out,
    input wire logic data_oe_out,
    input wire logic io_space_request_n_out,
    input wire logic memory_space_request_n_out,
    input wire logic space_request_oe_out,
    input wire logic read_n_out,
    input wire logic write_n_out,
    input wire logic strobe_oe_out,
    input wire logic addr_oe_out,
    input wire logic instruction_fetch_flag_n_out,
    input wire logic bus_release_grant_n_out,
    input wire logic int_take_out,
    input wire logic int_nmi_out,
    input wire logic instr_end_in,
    input wire logic irq_enable_in
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);
    chk_data_own_write: assert property (
        data_oe_out |-> read_n_out && bus_release_grant_n_out)
        else $error("data driven outside own write");
    chk_one_space: assert property (
        space_request_oe_out |-> io_space_request_n_out
        || memory_space_request_n_out) else $error("both spaces low");
    chk_strobe_space: assert property (
        strobe_oe_out && !(read_n_out && write_n_out) |->
        io_space_request_n_out != memory_space_request_n_out)
        else $error("strobe without one space request");
    chk_strobe_excl: assert property (
        strobe_oe_out |-> read_n_out || write_n_out)
        else $error("read and write both low");
    chk_grant_float: assert property (
        !bus_release_grant_n_out |-> !space_request_oe_out
        && !strobe_oe_out && !addr_oe_out && !data_oe_out)
        else $error("pins driven while granted");
    chk_float_first: assert property (
        $fell(bus_release_grant_n_out) |->
        !$past(strobe_oe_out) && !$past(addr_oe_out))
        else $error("grant before float");
    chk_wait_stretch: assert property (
        !wait_n_in [*4] |=> !core_done_out)
        else $error("access ended during wait");
    chk_fetch_qual: assert property (
        !instruction_fetch_flag_n_out |->
        !memory_space_request_n_out && !read_n_out)
        else $error("fetch flag outside memory read");
    chk_nmi_take: assert property (
        int_nmi_out |-> int_take_out) else $error("nmi without take");
    chk_take_at_end: assert property (
        int_take_out |-> $past(instr_end_in))
        else $error("interrupt taken outside instruction end");
    chk_mask_enable: assert property (
        int_take_out && !int_nmi_out |-> $past(irq_enable_in))
        else $error("masked source taken");
    cov_grant: cover property ($fell(bus_release_grant_n_out));
    cov_fetch: cover property (!instruction_fetch_flag_n_out);
    cov_nmi: cover property (int_nmi_out);
    cov_wait: cover property (!wait_n_in [*4] ##[1:20] core_done_out);
endmodule

bind cpu_external_bus_interface cpu_external_bus_interface_checker u_chk (.*);

// ==== ext_bus_memory_model.sv ====
// Byte store for memory and I/O space, optional slow answer
module ext_bus_memory_model (
    input  wire logic       clk_in,
    input  wire logic       slow_in,    // Hold wait low
    input  wire logic [8:0] idx_in,     // Space bit and low address
    input  wire logic       read_n_in,
    input  wire logic       write_n_in,
    input  wire logic [7:0] wdata_in,
    output logic      [7:0] rdata_out,
    output logic            wait_n_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] mem [512];
    logic [7:0] last = 8'h00;  // Last value put on the bus
    logic [3:0] cnt = 4'h0;    // Strobe cycles seen
    // Released bus shows no stale value, so the checks cannot pass on it
    assign rdata_out = !read_n_in ? mem[idx_in] : ~last;
    // Slow part holds wait until three strobe cycles have passed
    assign wait_n_out = !(slow_in && cnt < 4'h3);
    // Store writes, remember reads, count strobe cycles
    always @(posedge clk_in) begin
        if (!read_n_in) last <= mem[idx_in];
        if (!write_n_in) mem[idx_in] <= wdata_in;
        if (read_n_in && write_n_in) cnt <= 4'h0;
        else if (cnt < 4'hF) cnt <= cnt + 4'h1;
    end
endmodule

// ==== cpu_external_bus_interface_tb_top.sv ====
module cpu_external_bus_interface_tb_top
    import ext_bus_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_in, reset_n_in, instr_end_in, irq_enable_in, slow;
    logic wait_n_in, bus_release_request_n_in, nmi_n_in;
    core_req_s core_req_in;
    logic [7:0] irq_lines_in, data_pin_in, core_rdata_out, data_out;
    logic core_busy_out, core_done_out, int_take_out, int_nmi_out;
    logic addr_oe_out, data_oe_out, space_request_oe_out, strobe_oe_out;
    logic io_space_request_n_out, memory_space_request_n_out;
    logic read_n_out, write_n_out, instruction_fetch_flag_n_out;
    logic bus_release_grant_n_out;
    logic [2:0] int_vector_out;
    logic [23:0] addr_out;
    int failures = 0, n_tests = 0, lat, fast;
    cpu_external_bus_interface u_dut (.*);
    // Far side sees released strobes as idle high
    ext_bus_memory_model u_mem (
        .clk_in    (clk_in),
        .slow_in   (slow),
        .idx_in    ({~io_space_request_n_out, addr_out[7:0]}),
        .read_n_in (read_n_out | ~strobe_oe_out),
        .write_n_in(write_n_out | ~strobe_oe_out),
        .wdata_in  (data_out),
        .rdata_out (data_pin_in),
        .wait_n_out(wait_n_in)
    );
    always #25 clk_in = ~clk_in;
    task automatic stop_test();
        $display("tests %0d failures %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic cmp(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e) begin
            failures++;
            $display("CHECK FAILED at %0t: got %0h expected %0h", $time, g, e);
        end
    endtask
    // Bounded wait ran out: count it and end the run
    task automatic to(input int i);
        cmp(i < 20, 1);
        if (i >= 20) stop_test();
    endtask
    // One access; records which pins went active
    task automatic acc(input access_e k, input logic f,
                       input logic [7:0] a, input logic [7:0] d,
                       input logic [5:0] ex);
        int i;
        logic [5:0] seen;
        seen = 6'h00;
        @(posedge clk_in) core_req_in <= '{1'b1, k, f, 24'(a), d};
        @(posedge clk_in) core_req_in.valid <= 1'b0;
        for (i = 0; i < 20 && core_done_out !== 1'b1; i++) begin
            @(posedge clk_in);
            seen |= {~io_space_request_n_out, ~memory_space_request_n_out,
                     ~read_n_out, ~write_n_out,
                     ~instruction_fetch_flag_n_out, data_oe_out};
        end
        to(i);
        lat = i;
        cmp(seen, ex);
    endtask
    // Same address in both spaces, back to back
    task automatic t_rw();
        acc(ACC_MEM_WR, 1'b0, 8'h3C, 8'hA5, 6'h15);
        acc(ACC_IO_WR, 1'b0, 8'h3C, 8'h5A, 6'h25);
        acc(ACC_MEM_RD, 1'b0, 8'h3C, 8'h00, 6'h18);
        cmp(core_rdata_out, 8'hA5);
        acc(ACC_MEM_RD, 1'b1, 8'h3C, 8'h00, 6'h1A);
        cmp(core_rdata_out, 8'hA5);
        acc(ACC_IO_RD, 1'b0, 8'h3C, 8'h00, 6'h28);
        cmp(core_rdata_out, 8'h5A);
        fast = lat;
    endtask
    // Slow part stretches write and read
    task automatic t_slow();
        @(posedge clk_in) slow <= 1'b1;
        acc(ACC_MEM_WR, 1'b0, 8'h41, 8'hC3, 6'h15);
        cmp(lat >= fast + 2, 1);
        acc(ACC_MEM_RD, 1'b0, 8'h41, 8'h00, 6'h18);
        cmp(core_rdata_out, 8'hC3);
        @(posedge clk_in) slow <= 1'b0;
    endtask
    // Hand the bus away and take it back
    task automatic t_release();
        int i;
        @(posedge clk_in) bus_release_request_n_in <= 1'b0;
        for (i = 0; i < 20 && bus_release_grant_n_out !== 1'b0; i++)
            @(posedge clk_in);
        to(i);
        cmp(core_busy_out, 1'b1);
        cmp({space_request_oe_out, strobe_oe_out, addr_oe_out,
             data_oe_out}, 4'h0);
        @(posedge clk_in) bus_release_request_n_in <= 1'b1;
        for (i = 0; i < 20 && bus_release_grant_n_out !== 1'b1; i++)
            @(posedge clk_in);
        to(i);
        cmp({space_request_oe_out, strobe_oe_out, addr_oe_out}, 3'h7);
        cmp(core_busy_out, 1'b0);
    endtask
    // End an instruction and wait for the taken pulse
    task automatic end_instr();
        int i;
        @(posedge clk_in) instr_end_in <= 1'b1;
        @(posedge clk_in) instr_end_in <= 1'b0;
        for (i = 0; i < 20 && int_take_out !== 1'b1; i++) @(posedge clk_in);
        to(i);
    endtask
    // Nonmaskable with maskable lines pending and masked
    task automatic t_irq();
        @(posedge clk_in) irq_lines_in <= 8'h0C;
        nmi_n_in <= 1'b0;
        repeat (4) @(posedge clk_in);
        nmi_n_in <= 1'b1;
        end_instr();
        cmp(int_nmi_out, 1'b1);
        @(posedge clk_in) irq_enable_in <= 1'b1;
        end_instr();
        cmp({int_nmi_out, int_vector_out}, 4'h2);
        // Nonmaskable against an enabled, pending maskable line
        nmi_n_in <= 1'b0;
        repeat (4) @(posedge clk_in);
        nmi_n_in <= 1'b1;
        end_instr();
        cmp(int_nmi_out, 1'b1);
    endtask
    // Reset five clocks, then the scenarios
    initial begin
        clk_in = 1'b0;
        reset_n_in = 1'b0;
        slow = 1'b0;
        core_req_in = '0;
        instr_end_in = 1'b0;
        irq_enable_in = 1'b0;
        irq_lines_in = 8'h00;
        bus_release_request_n_in = 1'b1;
        nmi_n_in = 1'b1;
        repeat (5) @(posedge clk_in);
        reset_n_in <= 1'b1;
        repeat (3) @(posedge clk_in);
        t_rw();
        t_slow();
        t_release();
        t_irq();
        stop_test();
    end
endmodule
